// [logic/acr_consts.vh]
// constants for the calibration control register bank
// assumes an 8-bit register bus with a 12-bit address and the register clock only
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH
// register addresses
`define ACR_ADDR_CFG_PRI   12'h050
`define ACR_ADDR_CFG_SEC   12'h051
`define ACR_ADDR_BACK      12'h057
`define ACR_ADDR_PAT_OVR   12'h058
`define ACR_ADDR_VECTOR    12'h05A
`define ACR_ADDR_STATUS    12'h05B
`define ACR_ADDR_TCAL      12'h066
// reset values
`define ACR_RST_CFG_PRI    8'h06
`define ACR_RST_CFG_SEC    8'hF4
`define ACR_RST_BACK       8'h10
`define ACR_RST_PAT_OVR    8'h00
`define ACR_RST_VECTOR     8'h00
`define ACR_RST_TCAL       8'h02
// field positions
`define ACR_BIT_SCAN_EN    4
`define ACR_BIT_LAUNCH     3
`define ACR_RANGE_HI       6
`define ACR_RANGE_LO       4
`define ACR_BIT_CONTINUE   1
`define ACR_BIT_BG_EN      0
`define ACR_BIT_STOPPED    1
`define ACR_BIT_FIRST_DONE 0
`define ACR_BIT_PAT_EN     2
`define ACR_BIT_OVR_EN     1
`define ACR_BIT_T_AUTO     0
// status reserved bits 7-2 read as 000010
`define ACR_STAT_RSVD      6'h02
`define ACR_BYTE_ZERO      8'h00
`endif

// [logic/acr_sync.v]
// two-flop synchroniser for a single level
// assumes the destination clock is the only clock; reset is asynchronous active low
`timescale 1ns/1ps
module acr_sync
(
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // level in and synchronised level out
  input  wire din,
  output reg  dout
);
  reg meta;

  // first stage feeds only the second stage
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [logic/acr_regs.v]
// calibration control and status register bank
// assumes synchronous byte-wide register access; calibration engine is a simple stand-in on the same clock
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_regs
#(
  parameter CAL_CYCLES = 64,
  parameter VEC_DEPTH  = 16
)
(
  // clock and reset
  input  wire        CLOCK,
  input  wire        ARST_N,
  // register access
  input  wire [11:0] ADDR,
  input  wire        WR_EN,
  input  wire        RD_EN,
  input  wire [7:0]  WDATA,
  output reg  [7:0]  RDATA,
  // calibration side
  output reg  [2:0]  CAL_RANGE,
  output reg         CAL_BUSY,
  output reg         CAL_START,
  output wire        SCAN_EN,
  output wire        PATTERN_EN,
  output wire        OVERRANGE_EN,
  output wire        TIMING_AUTO
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_BACK = 2'h2;

  reg [7:0]  cfg_pri;
  reg [7:0]  cfg_sec;
  reg [7:0]  back_ctl;
  reg [7:0]  pat_ovr;
  reg [7:0]  tcal;
  reg [7:0]  vec_mem [0:VEC_DEPTH-1];
  reg [3:0]  vec_ptr;
  reg [1:0]  state;
  reg [15:0] cal_cnt;
  reg        first_done;
  reg        launch_tgl;
  reg        launch_seen;
  reg [2:0]  range_hold;
  wire       launch_sync;
  wire       launch_pulse;
  wire       wr_launch;
  wire       stopped;
  wire       cont_sync;

  assign wr_launch    = WR_EN && (ADDR == `ACR_ADDR_CFG_PRI) && WDATA[`ACR_BIT_LAUNCH];
  assign SCAN_EN      = cfg_pri[`ACR_BIT_SCAN_EN];
  assign PATTERN_EN   = pat_ovr[`ACR_BIT_PAT_EN];
  assign OVERRANGE_EN = pat_ovr[`ACR_BIT_OVR_EN];
  assign TIMING_AUTO  = tcal[`ACR_BIT_T_AUTO];
  assign stopped      = (state == ST_IDLE);

  // writes; the launch bit is cleared by hardware on acceptance
  always @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cfg_pri  <= `ACR_RST_CFG_PRI;
      cfg_sec  <= `ACR_RST_CFG_SEC;
      back_ctl <= `ACR_RST_BACK;
      pat_ovr  <= `ACR_RST_PAT_OVR;
      tcal     <= `ACR_RST_TCAL;
      launch_tgl <= 1'b0;
    end
    else
    begin
      if (WR_EN)
      begin
        case (ADDR)
          `ACR_ADDR_CFG_PRI: cfg_pri  <= WDATA;
          `ACR_ADDR_CFG_SEC: cfg_sec  <= WDATA;
          `ACR_ADDR_BACK:    back_ctl <= WDATA;
          `ACR_ADDR_PAT_OVR: pat_ovr  <= WDATA;
          `ACR_ADDR_TCAL:    tcal     <= WDATA;
          default:           ;
        endcase
      end
      // launch event handed across as a toggle
      if (wr_launch)
        launch_tgl <= ~launch_tgl;
      // accepted request clears the launch bit; a fresh write wins
      if (launch_pulse && !wr_launch)
        cfg_pri[`ACR_BIT_LAUNCH] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // crossing into the calibration side
  // ----------------------------------------------------------------
  acr_sync u_launch_sync
  (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .din    (launch_tgl),
    .dout   (launch_sync)
  );

  acr_sync u_cont_sync
  (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .din    (back_ctl[`ACR_BIT_CONTINUE]),
    .dout   (cont_sync)
  );

  assign launch_pulse = launch_sync ^ launch_seen;

  // the range setting is sampled only at launch, so later range writes cannot disturb a run
  always @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      launch_seen <= 1'b0;
      range_hold  <= 3'h0;
    end
    else
    begin
      launch_seen <= launch_sync;
      if (launch_pulse)
        range_hold <= cfg_sec[`ACR_RANGE_HI:`ACR_RANGE_LO];
    end
  end

  // ----------------------------------------------------------------
  // calibration sequencer stand-in
  // ----------------------------------------------------------------
  // launch forces a restart in the run state from count zero even mid-run
  always @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state      <= ST_IDLE;
      cal_cnt    <= 16'h0000;
      first_done <= 1'b0;
      CAL_BUSY   <= 1'b0;
      CAL_START  <= 1'b0;
      CAL_RANGE  <= 3'h0;
    end
    else
    begin
      CAL_START <= launch_pulse;
      CAL_RANGE <= range_hold;
      if (launch_pulse)
      begin
        state    <= ST_RUN;
        cal_cnt  <= 16'h0000;
        CAL_BUSY <= 1'b1;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            CAL_BUSY <= 1'b0;
            if (cont_sync && back_ctl[`ACR_BIT_BG_EN] && first_done)
            begin
              state    <= ST_BACK;
              CAL_BUSY <= 1'b1;
            end
          end
          ST_RUN:
          begin
            if (cal_cnt == CAL_CYCLES[15:0] - 16'h0001)
            begin
              first_done <= 1'b1;
              state      <= (cont_sync && back_ctl[`ACR_BIT_BG_EN]) ? ST_BACK : ST_IDLE;
              CAL_BUSY   <= cont_sync && back_ctl[`ACR_BIT_BG_EN];
            end
            else
              cal_cnt <= cal_cnt + 16'h0001;
          end
          ST_BACK:
          begin
            // background run ends only after continue is cleared
            if (!cont_sync)
            begin
              state    <= ST_IDLE;
              CAL_BUSY <= 1'b0;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration vector scan register
  // ----------------------------------------------------------------
  // sequential access through a pointer; ignored unless scan is enabled
  always @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      vec_ptr <= 4'h0;
    else if (SCAN_EN && (ADDR == `ACR_ADDR_VECTOR) && (WR_EN || RD_EN))
      vec_ptr <= (vec_ptr == VEC_DEPTH[3:0] - 4'h1) ? 4'h0 : vec_ptr + 4'h1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < VEC_DEPTH; gi = gi + 1)
    begin : g_vec
      always @(posedge CLOCK or negedge ARST_N)
      begin
        if (!ARST_N)
          vec_mem[gi] <= `ACR_RST_VECTOR;
        else if (WR_EN && SCAN_EN && (ADDR == `ACR_ADDR_VECTOR) && (vec_ptr == gi))
          vec_mem[gi] <= WDATA;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // registered read; unmapped addresses return zero
  always @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      RDATA <= `ACR_BYTE_ZERO;
    else if (RD_EN)
    begin
      case (ADDR)
        `ACR_ADDR_CFG_PRI: RDATA <= cfg_pri;
        `ACR_ADDR_CFG_SEC: RDATA <= cfg_sec;
        `ACR_ADDR_BACK:    RDATA <= back_ctl;
        `ACR_ADDR_PAT_OVR: RDATA <= pat_ovr;
        `ACR_ADDR_VECTOR:  RDATA <= SCAN_EN ? vec_mem[vec_ptr] : `ACR_BYTE_ZERO;
        `ACR_ADDR_STATUS:  RDATA <= {`ACR_STAT_RSVD, stopped, first_done};
        `ACR_ADDR_TCAL:    RDATA <= tcal;
        default:           RDATA <= `ACR_BYTE_ZERO;
      endcase
    end
  end
endmodule

// [dv/acr_regs_asserts.sv]
// port assertions for the calibration register bank
// assumes a bind onto acr_regs with its single register clock
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_regs_asserts
(
  // clock and reset
  input wire        CLOCK,
  input wire        ARST_N,
  // register access and calibration side
  input wire [11:0] ADDR,
  input wire        WR_EN,
  input wire        RD_EN,
  input wire [7:0]  WDATA,
  input wire [7:0]  RDATA,
  input wire [2:0]  CAL_RANGE,
  input wire        CAL_BUSY,
  input wire        CAL_START,
  input wire        SCAN_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // primary config write; the launch toggle crosses two flops, so start lags
  wire prim_wr = WR_EN && ADDR == `ACR_ADDR_CFG_PRI;
  launch_start_a: assert property (prim_wr && WDATA[3] |-> ##[2:5] CAL_START) else $error("no start");
  start_pulse_a: assert property (CAL_START |=> !CAL_START) else $error("start too long");
  start_busy_a: assert property (CAL_START |-> CAL_BUSY) else $error("start not busy");
  busy_run_a: assert property ($rose(CAL_BUSY) |-> CAL_BUSY[*4]) else $error("busy too short");
  range_capt_a: assert property (!$stable(CAL_RANGE) |-> CAL_START || $past(CAL_START))
    else $error("range moved");
  scan_en_a: assert property (prim_wr |=> SCAN_EN == $past(WDATA[4])) else $error("scan enable");
  scan_off_a: assert property (RD_EN && ADDR == `ACR_ADDR_VECTOR && !SCAN_EN |=> RDATA == `ACR_BYTE_ZERO)
    else $error("scan read open");
  rdata_hold_a: assert property (!RD_EN |=> $stable(RDATA)) else $error("read data moved");
endmodule
bind acr_regs acr_regs_asserts u_chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .ADDR(ADDR), .WR_EN(WR_EN),
  .RD_EN(RD_EN), .WDATA(WDATA), .RDATA(RDATA), .CAL_RANGE(CAL_RANGE), .CAL_BUSY(CAL_BUSY),
  .CAL_START(CAL_START), .SCAN_EN(SCAN_EN));

// [dv/acr_regs_test.sv]
// self-checking bench for the calibration register bank
// assumes acr_regs with a shorter run count, still long enough that a relaunch lands mid-run
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_regs_test;
  reg        clock;
  reg        arst_n;
  reg [11:0] addr;
  reg        wr_en;
  reg        rd_en;
  reg [7:0]  wdata;
  reg [7:0]  q;
  wire [7:0] rdata;
  wire [2:0] cal_range;
  wire       cal_busy;
  wire       cal_start;
  wire       scan_en;
  wire       pat_en;
  wire       ovr_en;
  wire       t_auto;
  integer    fails;
  integer    n_compared;
  integer    i;
  acr_regs #(.CAL_CYCLES(32), .VEC_DEPTH(16)) uut (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr),
    .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata), .CAL_RANGE(cal_range),
    .CAL_BUSY(cal_busy), .CAL_START(cal_start), .SCAN_EN(scan_en), .PATTERN_EN(pat_en),
    .OVERRANGE_EN(ovr_en), .TIMING_AUTO(t_auto));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task tally_and_finish;
  begin
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // a wait that ran out counts as a mismatch and ends the run
  task give_up(input integer n);
  begin
    if (i >= n)
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  endtask
  // each access idles a cycle first, so strobes never toggle twice in one step
  task wr(input [11:0] a, input [7:0] d);
  begin
    @(negedge clock);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
  end
  endtask
  // plain read into q; polling uses it so a changing status is not counted as a mismatch
  task rd(input [11:0] a);
  begin
    @(negedge clock);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    q = rdata;
  end
  endtask
  task rdchk(input [11:0] a, input [7:0] exp);
  begin
    rd(a);
    chk(q, exp);
  end
  endtask
  task wait_start;
  begin
    for (i = 0; i < 20 && cal_start !== 1'b1; i = i + 1)
      @(negedge clock);
    give_up(20);
  end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
  begin
    rdchk(`ACR_ADDR_CFG_PRI, `ACR_RST_CFG_PRI);
    rdchk(`ACR_ADDR_CFG_SEC, `ACR_RST_CFG_SEC);
    rdchk(`ACR_ADDR_BACK, `ACR_RST_BACK);
    rdchk(`ACR_ADDR_STATUS, 8'h0A);
    chk(scan_en, 8'h00);
  end
  endtask
  task t_fields;
  begin
    wr(`ACR_ADDR_CFG_PRI, 8'hE1);
    rdchk(`ACR_ADDR_CFG_PRI, 8'hE1);
    wr(`ACR_ADDR_CFG_SEC, 8'h84);
    rdchk(`ACR_ADDR_CFG_SEC, 8'h84);
    wr(`ACR_ADDR_CFG_PRI, 8'h16);
    chk(scan_en, 8'h01);
  end
  endtask
  // pattern, over-range and timing enables follow their bits; status ignores writes
  task t_misc;
  begin
    rdchk(`ACR_ADDR_PAT_OVR, `ACR_RST_PAT_OVR);
    rdchk(`ACR_ADDR_TCAL, `ACR_RST_TCAL);
    chk(t_auto, 8'h00);
    wr(`ACR_ADDR_PAT_OVR, 8'h04);
    chk(pat_en, 8'h01);
    chk(ovr_en, 8'h00);
    wr(`ACR_ADDR_PAT_OVR, 8'h02);
    chk(pat_en, 8'h00);
    chk(ovr_en, 8'h01);
    wr(`ACR_ADDR_TCAL, 8'h03);
    chk(t_auto, 8'h01);
    rdchk(`ACR_ADDR_TCAL, 8'h03);
    wr(`ACR_ADDR_STATUS, 8'hFF);
    rdchk(`ACR_ADDR_STATUS, 8'h0A);
  end
  endtask
  // pointer wraps after sixteen steps, so the reads replay the writes
  task t_scan;
  begin
    for (i = 0; i < 16; i = i + 1)
      wr(`ACR_ADDR_VECTOR, 8'h11 * i[7:0]);
    for (i = 0; i < 16; i = i + 1)
      rdchk(`ACR_ADDR_VECTOR, 8'h11 * i[7:0]);
    wr(`ACR_ADDR_CFG_PRI, 8'h06);
    rdchk(`ACR_ADDR_VECTOR, 8'h00);
  end
  endtask
  task t_launch;
  begin
    wr(`ACR_ADDR_CFG_SEC, 8'hD4);
    wr(`ACR_ADDR_CFG_PRI, 8'h0E);
    wait_start;
    // link enable off-then-on after a launch is owed by the link block, not this bank
    // range output is registered once more, so it lags the start pulse by a cycle
    @(negedge clock);
    chk(cal_range, 8'h05);
    chk(cal_busy, 8'h01);
    rdchk(`ACR_ADDR_CFG_PRI, 8'h06);
    rdchk(`ACR_ADDR_STATUS, 8'h08);
    wr(`ACR_ADDR_CFG_SEC, 8'h84);
    wr(`ACR_ADDR_CFG_PRI, 8'h0E);
    wait_start;
    @(negedge clock);
    chk(cal_range, 8'h00);
    repeat (24) @(negedge clock);
    chk(cal_busy, 8'h01);
    for (i = 0; i < 40 && cal_busy !== 1'b0; i = i + 1)
      @(negedge clock);
    give_up(40);
    rdchk(`ACR_ADDR_STATUS, 8'h0B);
  end
  endtask
  task t_back;
  begin
    wr(`ACR_ADDR_BACK, 8'h13);
    // continue crosses two flops before the background run shows in status
    repeat (2) @(negedge clock);
    rdchk(`ACR_ADDR_STATUS, 8'h09);
    wr(`ACR_ADDR_BACK, 8'h11);
    rdchk(`ACR_ADDR_STATUS, 8'h09);
    for (i = 0; i < 20 && q[1] !== 1'b1; i = i + 1)
      rd(`ACR_ADDR_STATUS);
    give_up(20);
    chk(q, 8'h0B);
  end
  endtask
  // a reset in mid-run drops the run and reloads every register
  task t_reset_mid;
  begin
    wr(`ACR_ADDR_CFG_PRI, 8'h0E);
    wait_start;
    repeat (4) @(negedge clock);
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    rdchk(`ACR_ADDR_CFG_SEC, `ACR_RST_CFG_SEC);
    rdchk(`ACR_ADDR_BACK, `ACR_RST_BACK);
    rdchk(`ACR_ADDR_STATUS, 8'h0A);
  end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    arst_n = 1'b0;
    addr = 12'h000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
    fails = 0;
    n_compared = 0;
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    t_reset;
    t_fields;
    t_misc;
    t_scan;
    t_launch;
    t_back;
    t_reset_mid;
    tally_and_finish;
  end
endmodule
